// >>> rtl/cmpblk_top.sv
`default_nettype none
module cmpblk_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comp_raw,
  input wire logic [5:0] pwm_in,
  input wire logic [3:0] ext_in,
  input wire logic [7:0] filt_clk_in,
  output logic comparator_on,
  output logic result_pin,
  output logic result_pin_enable,
  output logic positive_input_select,
  output logic [1:0] negative_channel_select,
  output logic reference_source_select,
  output logic [1:0] reference_pin_output_enable,
  output logic event_pulse,
  output logic irq
);
  import cmpblk_pkg::*;
  logic [15:0] ctrl_reg;
  logic [15:0] msrc_reg;
  logic [15:0] mgate_reg;
  logic [15:0] fltr_reg;
  logic [15:0] ref_reg;
  logic irq_stat_reg;
  logic irq_en_reg;
  logic [1:0] comp_sync_reg;
  logic [7:0] fclk_s1_reg;
  logic [7:0] fclk_s2_reg;
  logic [7:0] fclk_d_reg;
  logic [2:0] div_reg;
  logic [7:0] pre_reg;
  logic adj_d_reg;
  logic filt_out;
  logic adj;
  logic blank;
  logic tick;
  logic fire;
  logic wr;
  logic clr_evt;
  logic [31:0] rd_next;
  cmpblk_state_t st_reg;
  cmpblk_mask_if mif ();
  assign mif.src_sel = msrc_reg;
  assign mif.gate_ctl = mgate_reg;
  assign mif.pwm = pwm_in;
  assign mif.ext = ext_in;
  assign blank = mif.blank;
  cmpblk_mask u_mask (.m(mif));
  function automatic logic [15:0] wmask(input logic [31:0] d, input logic [15:0] k);
    wmask = d[15:0] & k;
  endfunction : wmask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_sync_reg <= 2'h0;
      fclk_s1_reg <= 8'h00;
      fclk_s2_reg <= 8'h00;
      fclk_d_reg <= 8'h00;
    end else begin
      comp_sync_reg <= {comp_sync_reg[0], comp_raw};
      fclk_s1_reg <= filt_clk_in;
      fclk_s2_reg <= fclk_s1_reg;
      fclk_d_reg <= fclk_s2_reg;
    end
  end
  logic src_edge;
  assign src_edge = fclk_s2_reg[fltr_reg[CMPBLK_FSEL_LO +: 3]]
    & ~fclk_d_reg[fltr_reg[CMPBLK_FSEL_LO +: 3]];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 8'h00;
    end else if (src_edge) begin
      pre_reg <= (pre_reg >= 8'((1 << div_reg) - 1)) ? 8'h00 : pre_reg + 8'h01;
    end
  end
  assign div_reg = fltr_reg[2:0];
  assign tick = src_edge && (pre_reg >= 8'((1 << div_reg) - 1));
  cmpblk_filter #(.SAMPLES(CMPBLK_FILT_SAMPLES)) u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .enable(fltr_reg[CMPBLK_FEN]),
    .din(comp_sync_reg[1]),
    .dout(filt_out)
  );
  // Blanking forces the adjusted output to read as the selected level.
  always_comb begin
    adj = filt_out ^ ctrl_reg[CMPBLK_INV];
    if (blank && (adj != mgate_reg[CMPBLK_BLANK_LEVEL_SELECT])) begin
      adj = mgate_reg[CMPBLK_BLANK_LEVEL_SELECT];
    end
  end
  always_comb begin
    case (ctrl_reg[CMPBLK_EDGE_LO +: 2])
      CMPBLK_EDGE_RISE: fire = adj & ~adj_d_reg;
      CMPBLK_EDGE_FALL: fire = ~adj & adj_d_reg;
      CMPBLK_EDGE_ANY: fire = adj ^ adj_d_reg;
      default: fire = 1'b0;
    endcase
    fire = fire & ctrl_reg[CMPBLK_ON] & (st_reg != CMPBLK_LATCHED);
  end
  assign wr = psel && penable && pwrite;
  assign clr_evt = wr && (paddr == CMPBLK_OFS_CTRL) && !pwdata[CMPBLK_EVT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= CMPBLK_IDLE;
      adj_d_reg <= 1'b0;
      event_pulse <= 1'b0;
    end else begin
      adj_d_reg <= adj;
      event_pulse <= fire;
      case (st_reg)
        CMPBLK_IDLE: begin
          st_reg <= ctrl_reg[CMPBLK_ON] ? CMPBLK_ARMED : CMPBLK_IDLE;
          if (fire) begin
            st_reg <= CMPBLK_LATCHED;
          end
        end
        CMPBLK_ARMED: st_reg <= fire ? CMPBLK_LATCHED : CMPBLK_ARMED;
        CMPBLK_LATCHED: st_reg <= clr_evt ? CMPBLK_ARMED : CMPBLK_LATCHED;
        default: st_reg <= CMPBLK_IDLE;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 16'h0000;
    end else begin
      if (wr && paddr == CMPBLK_OFS_CTRL) begin
        ctrl_reg <= wmask(pwdata, CMPBLK_CTRL_MASK & ~16'h0300);
        ctrl_reg[CMPBLK_EVT] <= pwdata[CMPBLK_EVT] & ctrl_reg[CMPBLK_EVT];
      end
      if (fire) begin
        ctrl_reg[CMPBLK_EVT] <= 1'b1;
      end
      ctrl_reg[CMPBLK_RES] <= adj;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msrc_reg <= 16'h0000;
      mgate_reg <= 16'h0000;
      fltr_reg <= 16'h0000;
      ref_reg <= 16'h0000;
      irq_en_reg <= 1'b0;
    end else if (wr) begin
      case (paddr)
        CMPBLK_OFS_MSRC: msrc_reg <= wmask(pwdata, CMPBLK_MSRC_MASK);
        CMPBLK_OFS_MGATE: mgate_reg <= wmask(pwdata, CMPBLK_MGATE_MASK);
        CMPBLK_OFS_FLTR: fltr_reg <= wmask(pwdata, CMPBLK_FLTR_MASK);
        CMPBLK_OFS_REF: ref_reg <= wmask(pwdata, CMPBLK_REF_MASK);
        CMPBLK_OFS_IRQ_EN: irq_en_reg <= pwdata[0];
        default: irq_en_reg <= irq_en_reg;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 1'b0;
    end else if (fire) begin
      irq_stat_reg <= 1'b1;
    end else if (wr && paddr == CMPBLK_OFS_IRQ_CLR && pwdata[0]) begin
      irq_stat_reg <= 1'b0;
    end
  end
  always_comb begin
    case (paddr)
      CMPBLK_OFS_CTRL: rd_next = {16'h0000, ctrl_reg};
      CMPBLK_OFS_MSRC: rd_next = {16'h0000, msrc_reg};
      CMPBLK_OFS_MGATE: rd_next = {16'h0000, mgate_reg};
      CMPBLK_OFS_FLTR: rd_next = {16'h0000, fltr_reg};
      CMPBLK_OFS_REF: rd_next = {16'h0000, ref_reg};
      CMPBLK_OFS_IRQ_STAT: rd_next = {31'h0, irq_stat_reg};
      CMPBLK_OFS_IRQ_EN: rd_next = {31'h0, irq_en_reg};
      default: rd_next = 32'h0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? rd_next : 32'h0;
      pslverr <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_on <= 1'b0;
      result_pin <= 1'b0;
      result_pin_enable <= 1'b0;
      positive_input_select <= 1'b0;
      negative_channel_select <= 2'h0;
      reference_source_select <= 1'b0;
      reference_pin_output_enable <= 2'h0;
      irq <= 1'b0;
    end else begin
      comparator_on <= ctrl_reg[CMPBLK_ON];
      result_pin <= ctrl_reg[CMPBLK_RES];
      result_pin_enable <= ctrl_reg[CMPBLK_PINEN];
      positive_input_select <= ctrl_reg[CMPBLK_PSEL];
      negative_channel_select <= ctrl_reg[1:0];
      reference_source_select <= ref_reg[CMPBLK_RSEL];
      reference_pin_output_enable <= {ref_reg[CMPBLK_ROE2], ref_reg[CMPBLK_ROE1]};
      irq <= irq_stat_reg & irq_en_reg;
    end
  end
  property p_no_fire_latched;
    @(posedge pclk) disable iff (!presetn) (st_reg == CMPBLK_LATCHED) |-> !fire;
  endproperty
  a_no_fire_latched: assert property (p_no_fire_latched) else $error("event while latched");
  property p_off_silent;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_reg[CMPBLK_EDGE_LO +: 2] == CMPBLK_EDGE_OFF) |-> !fire;
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("event while disabled");
  property p_rise_only;
    @(posedge pclk) disable iff (!presetn)
      (fire && ctrl_reg[CMPBLK_EDGE_LO +: 2] == CMPBLK_EDGE_RISE) |-> (adj && !adj_d_reg);
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("rise event without rise");
  property p_res_track;
    @(posedge pclk) disable iff (!presetn) ##1 ctrl_reg[CMPBLK_RES] == $past(adj);
  endproperty
  a_res_track: assert property (p_res_track) else $error("result bit mismatch");
  property p_pin_follow;
    @(posedge pclk) disable iff (!presetn) ##1 result_pin == $past(ctrl_reg[CMPBLK_RES]);
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin mismatch");
  property p_flag_sets;
    @(posedge pclk) disable iff (!presetn) fire |=> ctrl_reg[CMPBLK_EVT] && irq_stat_reg;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("flag not set");
  property p_chan;
    @(posedge pclk) disable iff (!presetn) ##1 negative_channel_select == $past(ctrl_reg[1:0]);
  endproperty
  a_chan: assert property (p_chan) else $error("channel mismatch");
  property p_resv;
    @(posedge pclk) disable iff (!presetn) (fltr_reg & ~CMPBLK_FLTR_MASK) == 16'h0000;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_flag_blocks;
    @(posedge pclk) disable iff (!presetn)
      ctrl_reg[CMPBLK_EVT] |-> !fire;
  endproperty
  a_flag_blocks: assert property (p_flag_blocks) else $error("event while flag set");
  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      ##1 irq == ($past(irq_stat_reg) & $past(irq_en_reg));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");
  property p_any_fire;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_reg[CMPBLK_ON] && !ctrl_reg[CMPBLK_EVT] && (adj != adj_d_reg)
        && ctrl_reg[CMPBLK_EDGE_LO +: 2] == CMPBLK_EDGE_ANY) |-> fire;
  endproperty
  a_any_fire: assert property (p_any_fire) else $error("change without event");
  property p_fall_only;
    @(posedge pclk) disable iff (!presetn)
      (fire && ctrl_reg[CMPBLK_EDGE_LO +: 2] == CMPBLK_EDGE_FALL) |-> (!adj && adj_d_reg);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("fall event without fall");
  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
      ##1 event_pulse == $past(fire);
  endproperty
  a_pulse: assert property (p_pulse) else $error("event pulse mismatch");
  property p_pos_sel;
    @(posedge pclk) disable iff (!presetn)
      ##1 positive_input_select == $past(ctrl_reg[CMPBLK_PSEL]);
  endproperty
  a_pos_sel: assert property (p_pos_sel) else $error("positive select mismatch");
  property p_ref_sel;
    @(posedge pclk) disable iff (!presetn)
      ##1 reference_source_select == $past(ref_reg[CMPBLK_RSEL]);
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference select mismatch");
  property p_ref_oe;
    @(posedge pclk) disable iff (!presetn)
      ##1 reference_pin_output_enable
        == {$past(ref_reg[CMPBLK_ROE2]), $past(ref_reg[CMPBLK_ROE1])};
  endproperty
  a_ref_oe: assert property (p_ref_oe) else $error("reference pin enable mismatch");
  property p_pin_en;
    @(posedge pclk) disable iff (!presetn)
      ##1 result_pin_enable == $past(ctrl_reg[CMPBLK_PINEN]);
  endproperty
  a_pin_en: assert property (p_pin_en) else $error("pin enable mismatch");
  property p_blank_level;
    @(posedge pclk) disable iff (!presetn)
      blank |-> adj == mgate_reg[CMPBLK_BLANK_LEVEL_SELECT];
  endproperty
  a_blank_level: assert property (p_blank_level) else $error("blanked level passed");
  property p_resv_all;
    @(posedge pclk) disable iff (!presetn)
      ((ctrl_reg & ~CMPBLK_CTRL_MASK) | (msrc_reg & ~CMPBLK_MSRC_MASK)
        | (mgate_reg & ~CMPBLK_MGATE_MASK) | (ref_reg & ~CMPBLK_REF_MASK)) == 16'h0000;
  endproperty
  a_resv_all: assert property (p_resv_all) else $error("reserved bit set");
  property p_filt_hold;
    @(posedge pclk) disable iff (!presetn)
      (fltr_reg[CMPBLK_FEN] && !tick) ##1 fltr_reg[CMPBLK_FEN] |-> $stable(filt_out);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter output moved");
endmodule : cmpblk_top
`default_nettype wire

// >>> include/cmpblk_pkg.sv
// Summary of operation
// - Edge code 11 fires on any output change; code 00 disables events.
// - Code 01 fires on rising, 10 on falling adjusted output, flag clear.
// - Output invert flips the result before result bit, pin and event logic.
// - Positive input select picks internal reference when set, positive pin when clear.
// - Negative channel picks opamp three, two, one outputs, or the negative pin.
// - Mask selectors pick fault four, fault two, trigger outputs, PWM; rest reserved.
// - OR gate takes each mask input, true or inverted, when its enable is set.
// - AND gate takes each mask input, true or inverted, when its enable is set.
// - AND result feeds OR true or inverted by its two enables.
// - Reference source select picks external reference pin or internal ladder.
// - Reference pin output enables drive the pin regardless of direction settings.
// - Unimplemented register bits ignore writes and read as zero.
`default_nettype none
package cmpblk_pkg;
  localparam logic [11:0] CMPBLK_OFS_CTRL = 12'h000;
  localparam logic [11:0] CMPBLK_OFS_MSRC = 12'h004;
  localparam logic [11:0] CMPBLK_OFS_MGATE = 12'h008;
  localparam logic [11:0] CMPBLK_OFS_FLTR = 12'h00c;
  localparam logic [11:0] CMPBLK_OFS_REF = 12'h010;
  localparam logic [11:0] CMPBLK_OFS_IRQ_STAT = 12'h014;
  localparam logic [11:0] CMPBLK_OFS_IRQ_EN = 12'h018;
  localparam logic [11:0] CMPBLK_OFS_IRQ_CLR = 12'h01c;
  localparam logic [15:0] CMPBLK_CTRL_MASK = 16'he3d3;
  localparam logic [15:0] CMPBLK_MSRC_MASK = 16'h0fff;
  localparam logic [15:0] CMPBLK_MGATE_MASK = 16'hbfff;
  localparam logic [15:0] CMPBLK_FLTR_MASK = 16'h007f;
  localparam logic [15:0] CMPBLK_REF_MASK = 16'h44ff;
  localparam int CMPBLK_ON = 15;
  localparam int CMPBLK_PINEN = 14;
  localparam int CMPBLK_INV = 13;
  localparam int CMPBLK_EVT = 9;
  localparam int CMPBLK_RES = 8;
  localparam int CMPBLK_EDGE_LO = 6;
  localparam int CMPBLK_PSEL = 4;
  localparam int CMPBLK_BLANK_LEVEL_SELECT = 15;
  localparam int CMPBLK_FEN = 3;
  localparam int CMPBLK_FSEL_LO = 4;
  localparam int CMPBLK_RSEL = 10;
  localparam int CMPBLK_ROE2 = 14;
  localparam int CMPBLK_ROE1 = 6;
  localparam int CMPBLK_FILT_SAMPLES = 3;
  localparam logic [1:0] CMPBLK_EDGE_OFF = 2'h0;
  localparam logic [1:0] CMPBLK_EDGE_RISE = 2'h1;
  localparam logic [1:0] CMPBLK_EDGE_FALL = 2'h2;
  localparam logic [1:0] CMPBLK_EDGE_ANY = 2'h3;
  typedef enum logic [2:0] {
    CMPBLK_IDLE = 3'b001,
    CMPBLK_ARMED = 3'b010,
    CMPBLK_LATCHED = 3'b100
  } cmpblk_state_t;
endpackage : cmpblk_pkg
`default_nettype wire

// >>> include/cmpblk_mask_if.sv
`default_nettype none
interface cmpblk_mask_if;
  logic [15:0] src_sel;
  logic [15:0] gate_ctl;
  logic [5:0] pwm;
  logic [3:0] ext;
  logic blank;
  modport ctl (output src_sel, gate_ctl, pwm, ext, input blank);
  modport net (input src_sel, gate_ctl, pwm, ext, output blank);
endinterface : cmpblk_mask_if
`default_nettype wire

// >>> rtl/cmpblk_mask.sv
`default_nettype none
module cmpblk_mask (
  cmpblk_mask_if.net m
);
  import cmpblk_pkg::*;
  logic ma;
  logic mb;
  logic mc;
  logic andr;
  logic [5:0] g;
  function automatic logic pick(input logic [3:0] s, input logic [5:0] p, input logic [3:0] e);
    case (s)
      4'hf: pick = e[3];
      4'he: pick = e[2];
      4'hd: pick = e[1];
      4'hc: pick = e[0];
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: pick = p[s[2:0]];
      default: pick = 1'b0;
    endcase
  endfunction : pick
  always_comb begin
    ma = pick(m.src_sel[3:0], m.pwm, m.ext);
    mb = pick(m.src_sel[7:4], m.pwm, m.ext);
    mc = pick(m.src_sel[11:8], m.pwm, m.ext);
    g = m.gate_ctl[5:0];
    andr = (~g[1] | ma) & (~g[0] | ~ma) & (~g[3] | mb) & (~g[2] | ~mb)
      & (~g[5] | mc) & (~g[4] | ~mc) & (|g);
    m.blank = (m.gate_ctl[9] & ma) | (m.gate_ctl[8] & ~ma) | (m.gate_ctl[11] & mb)
      | (m.gate_ctl[10] & ~mb) | (m.gate_ctl[13] & mc) | (m.gate_ctl[12] & ~mc)
      | (m.gate_ctl[6] & andr) | (m.gate_ctl[7] & ~andr);
  end
endmodule : cmpblk_mask
`default_nettype wire

// >>> rtl/cmpblk_filter.sv
`default_nettype none
module cmpblk_filter #(
  parameter int SAMPLES = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic enable,
  input wire logic din,
  output logic dout
);
  logic [3:0] cnt_reg;
  logic held_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
      held_reg <= 1'b0;
    end else if (din == held_reg) begin
      cnt_reg <= 4'h0;
    end else if (tick) begin
      if (cnt_reg == 4'(SAMPLES - 1)) begin
        held_reg <= din;
        cnt_reg <= 4'h0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
  assign dout = enable ? held_reg : din;
endmodule : cmpblk_filter
`default_nettype wire

// >>> dv/comparator_event_blanking_control_tb.sv
`default_nettype none
module comparator_event_blanking_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cmpblk_pkg::*;
  localparam logic [11:0] OFS [8] = '{CMPBLK_OFS_CTRL, CMPBLK_OFS_MSRC, CMPBLK_OFS_MGATE,
    CMPBLK_OFS_FLTR, CMPBLK_OFS_REF, CMPBLK_OFS_IRQ_STAT, CMPBLK_OFS_IRQ_EN, 12'h020};
  localparam logic [31:0] WV [8] = '{32'h1c3d, 32'hffff, 32'hffff, 32'hffff, 32'hffff,
    32'hffff, 32'hffff, 32'hffff};
  localparam logic [31:0] EV [8] = '{32'h0011, 32'h0fff, 32'hbfff, 32'h007f, 32'h44ff,
    32'h0000, 32'h0001, 32'h0000};
  localparam logic [31:0] BS [3] = '{32'h000f, 32'h0000, 32'h000e};
  localparam logic [31:0] BG [3] = '{32'h0200, 32'h0042, 32'h0100};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic comp_raw = 1'b0;
  logic fr = 1'b0;
  logic [3:0] fcnt = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] pwm_in = 6'h00;
  logic [3:0] ext_in = 4'h0;
  logic [7:0] filt_clk_in = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, comparator_on, result_pin, result_pin_enable, positive_input_select;
  logic reference_source_select, event_pulse, irq;
  logic [1:0] negative_channel_select, reference_pin_output_enable;
  logic [31:0] expq [$];
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  cmpblk_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_raw(comp_raw), .pwm_in(pwm_in), .ext_in(ext_in),
    .filt_clk_in(filt_clk_in), .comparator_on(comparator_on), .result_pin(result_pin),
    .result_pin_enable(result_pin_enable), .positive_input_select(positive_input_select),
    .negative_channel_select(negative_channel_select),
    .reference_source_select(reference_source_select),
    .reference_pin_output_enable(reference_pin_output_enable), .event_pulse(event_pulse),
    .irq(irq));
  always #50 pclk = ~pclk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude;
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic evt(input logic e, input int n);
    logic got;
    got = 1'b0;
    repeat (n) begin
      @(posedge pclk);
      if (event_pulse === 1'b1) got = 1'b1;
    end
    chk("event_pulse", 32'(got), 32'(e));
  endtask : evt
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      chk("pslverr", 32'(pslverr), 32'h0);
      if (!pwrite) chk("prdata", prdata, expq.pop_front());
    end
  end
  always @(posedge pclk) begin
    fcnt <= fcnt + 4'h1;
    filt_clk_in <= fr ? {8{fcnt[2]}} : 8'h00;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    logic [31:0] v;
    logic e2;
    v = $urandom(32'hf7b68882);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(OFS[i], 32'h0);
      wr(OFS[i], WV[i]);
      rd(OFS[i], EV[i]);
    end
    repeat (3) @(posedge pclk);
    chk("ref_sel", 32'(reference_source_select), 32'h1);
    chk("ref_oe", 32'(reference_pin_output_enable), 32'h3);
    for (int i = 0; i < 8; i++) wr(OFS[i], 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = ($urandom() & 32'h5c3c) | 32'(i);
      wr(CMPBLK_OFS_CTRL, v);
      repeat (3) @(posedge pclk);
      chk("pos_sel", 32'(positive_input_select), 32'(v[4]));
      chk("neg_ch", 32'(negative_channel_select), 32'(i));
      chk("pin_en", 32'(result_pin_enable), 32'(v[14]));
      rd(CMPBLK_OFS_CTRL, v & 32'h4013);
    end
    wr(CMPBLK_OFS_IRQ_EN, 32'h1);
    wr(CMPBLK_OFS_CTRL, 32'h8040);
    comp_raw <= 1'b1;
    evt(1'b1, 12);
    chk("irq", 32'(irq), 32'h1);
    rd(CMPBLK_OFS_CTRL, 32'h8340);
    comp_raw <= 1'b0;
    evt(1'b0, 12);
    comp_raw <= 1'b1;
    evt(1'b0, 12);
    wr(CMPBLK_OFS_IRQ_EN, 32'h0);
    repeat (3) @(posedge pclk);
    chk("irq", 32'(irq), 32'h0);
    rd(CMPBLK_OFS_IRQ_STAT, 32'h1);
    wr(CMPBLK_OFS_IRQ_CLR, 32'h1);
    wr(CMPBLK_OFS_CTRL, 32'h8040);
    rd(CMPBLK_OFS_IRQ_STAT, 32'h0);
    rd(CMPBLK_OFS_CTRL, 32'h8140);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        v = 32'h8000 | (32'(j) << 13) | (32'(i) << 6);
        wr(CMPBLK_OFS_CTRL, v & 32'h7fff);
        comp_raw <= 1'b0;
        repeat (6) @(posedge pclk);
        wr(CMPBLK_OFS_CTRL, v);
        comp_raw <= 1'b1;
        evt(j ? i[1] : i[0], 12);
        wr(CMPBLK_OFS_CTRL, v);
        comp_raw <= 1'b0;
        e2 = j ? i[0] : i[1];
        evt(e2, 12);
        rd(CMPBLK_OFS_CTRL, v | (32'(j) << 8) | (32'(e2) << 9));
        chk("result_pin", 32'(result_pin), 32'(j));
        chk("comparator_on", 32'(comparator_on), 32'h1);
      end
    end
    ext_in <= 4'h8;
    pwm_in <= 6'($urandom()) | 6'h01;
    for (int k = 0; k < 3; k++) begin
      wr(CMPBLK_OFS_CTRL, 32'h0);
      comp_raw <= 1'b0;
      wr(CMPBLK_OFS_MSRC, BS[k]);
      wr(CMPBLK_OFS_MGATE, BG[k]);
      wr(CMPBLK_OFS_CTRL, 32'h8040);
      comp_raw <= 1'b1;
      evt(1'b0, 12);
      wr(CMPBLK_OFS_MGATE, 32'h0);
      evt(1'b1, 12);
    end
    wr(CMPBLK_OFS_CTRL, 32'h0);
    comp_raw <= 1'b0;
    wr(CMPBLK_OFS_FLTR, 32'h0008);
    repeat (6) @(posedge pclk);
    wr(CMPBLK_OFS_CTRL, 32'h8040);
    comp_raw <= 1'b1;
    evt(1'b0, 20);
    fr <= 1'b1;
    evt(1'b1, 80);
    conclude();
  end
endmodule : comparator_event_blanking_control_tb
`default_nettype wire
